// [design/fpe_pkg.sv]
`default_nettype none
package fpe_pkg;

	// ****************
	// register map
	// ****************
	localparam logic [15:0] OFF_CTL  = 16'hF400;
	localparam logic [15:0] OFF_KEY  = 16'hF410;
	localparam logic [15:0] OFF_ADDR = 16'hF420;
	localparam logic [15:0] OFF_DATA = 16'hF430;
	localparam logic [15:0] OFF_SRC  = 16'hF440;
	localparam logic [15:0] OFF_STAT = 16'hF450;
	localparam logic [15:0] OFF_MASK = 16'hF460;

	// ****************
	// control fields
	// ****************
	localparam int CTL_GO  = 15;
	localparam int CTL_ARM = 14;
	localparam int CTL_ERR = 13;
	localparam int OP_W    = 4;
	localparam int ST_DONE = 0;
	localparam int ST_ERR  = 1;
	localparam int ST_W    = 2;

	// ****************
	// operation codes
	// ****************
	localparam logic [3:0] OP_NONE = 4'h0;
	localparam logic [3:0] OP_WORD = 4'h1;
	localparam logic [3:0] OP_ROW  = 4'h3;
	localparam logic [3:0] OP_PAGE = 4'h4;
	localparam logic [3:0] OP_ALL  = 4'h5;

	// ****************
	// reset values and keys
	// ****************
	localparam logic [31:0] REG_RST = 32'h00000000;
	localparam logic [3:0]  OP_RST  = 4'h0;
	localparam logic [ST_W-1:0] ST_RST = 2'h0;
	// key values arbitrary
	localparam logic [31:0] KEY1_DEF = 32'h1234ABCD;
	localparam logic [31:0] KEY2_DEF = 32'hCDAB4321;

	// ****************
	// state types
	// ****************
	typedef enum logic [2:0] {
		UL_IDLE = 3'b001,
		UL_ONE  = 3'b010,
		UL_OPEN = 3'b100
	} fpe_ul_e;

	typedef enum logic [1:0] {
		SQ_IDLE = 2'b01,
		SQ_BUSY = 2'b10
	} fpe_sq_e;

endpackage : fpe_pkg
`default_nettype wire

// [design/fpe_sticky.sv]
`timescale 1ns/1ns
`default_nettype none
module fpe_sticky #(
	parameter int W = 2
) (
	// clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// set and clear
	input  wire logic [W-1:0] set,
	input  wire logic         clr,
	// flags
	output logic      [W-1:0] q
);

	// ****************
	// sticky flags, set wins over clear
	// ****************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else if (clr) begin
			q <= set;
		end else begin
			q <= q | set;
		end
	end

endmodule : fpe_sticky
`default_nettype wire

// [design/fpe_unlock.sv]
`timescale 1ns/1ns
`default_nettype none
module fpe_unlock #(
	parameter logic [31:0] KEY1 = fpe_pkg::KEY1_DEF,
	parameter logic [31:0] KEY2 = fpe_pkg::KEY2_DEF
) (
	// clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// bus events
	input  wire logic        key_wr,
	input  wire logic [31:0] key_val,
	input  wire logic        ctl_wr,
	input  wire logic        other,
	// state
	output logic             open
);

	fpe_pkg::fpe_ul_e st_q;
	fpe_pkg::fpe_ul_e st_d;

	// ****************
	// two key writes, then control write
	// ****************
	always_comb begin
		st_d = st_q;
		case (st_q)
			fpe_pkg::UL_IDLE: begin
				if (key_wr && key_val == KEY1) begin
					st_d = fpe_pkg::UL_ONE;
				end
			end
			fpe_pkg::UL_ONE: begin
				if (key_wr && key_val == KEY2) begin
					st_d = fpe_pkg::UL_OPEN;
				end else if (key_wr && key_val == KEY1) begin
					st_d = fpe_pkg::UL_ONE;
				end else if (key_wr || ctl_wr || other) begin
					st_d = fpe_pkg::UL_IDLE;
				end
			end
			fpe_pkg::UL_OPEN: begin
				if (key_wr && key_val == KEY1) begin
					st_d = fpe_pkg::UL_ONE;
				end else if (key_wr || ctl_wr || other) begin
					st_d = fpe_pkg::UL_IDLE;
				end
			end
			default: begin
				st_d = fpe_pkg::UL_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= fpe_pkg::UL_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign open = (st_q == fpe_pkg::UL_OPEN);

endmodule : fpe_unlock
`default_nettype wire

// [design/fpe_regs.sv]
// Notes on behaviour
// - key register takes writes but always reads back as zero
// - no flash operation starts unless the unlock sequence was done
// - full-array erase ignores the target address
// - page erase uses the target address to pick the page
// - row program uses the target address to pick the row
// - word program uses the target address to pick the word
// - program word register is cleared only by power-on reset
// - row program fetches data from the row source address
// - codes 1 word, 3 row, 4 page, 5 all; 0, 2, 6 do nothing
// - trigger sets only when armed and unlocked; hardware clears it when done
// - operation select is writable only while the arm bit is 0
// - sequence error flag set on failed operation, cleared on success or code 0, kept by other no-op codes
`timescale 1ns/1ns
`default_nettype none
module fpe_regs #(
	parameter logic [31:0] KEY1 = fpe_pkg::KEY1_DEF,
	parameter logic [31:0] KEY2 = fpe_pkg::KEY2_DEF
) (
	// clock and resets
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        por_n,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	// flash array side
	output logic             flash_req,
	output logic      [3:0]  flash_op,
	output logic      [31:0] flash_addr,
	output logic      [31:0] flash_wdata,
	output logic      [31:0] flash_src,
	input  wire logic        flash_done,
	input  wire logic        flash_fail,
	// interrupt
	output logic             irq
);

	// ****************
	// bus data phase
	// ****************
	logic        dp_vld_q;
	logic        dp_wr_q;
	logic [15:0] dp_addr_q;
	logic        rd_done_q;
	logic        acc;
	logic        rd_ph;
	logic        wr_ev;
	logic        rd_ev;

	assign acc = hsel && htrans[1] && hready;
	assign rd_ph = dp_vld_q && !dp_wr_q;
	assign wr_ev = dp_vld_q && dp_wr_q;
	assign rd_ev = rd_ph && !rd_done_q;
	assign hreadyout = !rd_ev;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_vld_q <= 1'b0;
			dp_wr_q <= 1'b0;
			dp_addr_q <= 16'h0000;
		end else if (hreadyout) begin
			dp_vld_q <= acc;
			dp_wr_q <= hwrite;
			dp_addr_q <= haddr[15:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= rd_ev;
		end
	end

	// ****************
	// address decode
	// ****************
	logic hit_ctl;
	logic hit_key;
	logic hit_addr;
	logic hit_data;
	logic hit_src;
	logic hit_stat;
	logic hit_mask;

	assign hit_ctl  = (dp_addr_q == fpe_pkg::OFF_CTL);
	assign hit_key  = (dp_addr_q == fpe_pkg::OFF_KEY);
	assign hit_addr = (dp_addr_q == fpe_pkg::OFF_ADDR);
	assign hit_data = (dp_addr_q == fpe_pkg::OFF_DATA);
	assign hit_src  = (dp_addr_q == fpe_pkg::OFF_SRC);
	assign hit_stat = (dp_addr_q == fpe_pkg::OFF_STAT);
	assign hit_mask = (dp_addr_q == fpe_pkg::OFF_MASK);

	// ****************
	// unlock tracking
	// ****************
	logic key_wr;
	logic ctl_wr;
	logic other;
	logic open;

	assign key_wr = wr_ev && hit_key;
	assign ctl_wr = wr_ev && hit_ctl;
	assign other = rd_ev || (wr_ev && !hit_key && !hit_ctl);

	fpe_unlock #(
		.KEY1(KEY1),
		.KEY2(KEY2)
	) u_unlock (
		.hclk(hclk),
		.hresetn(hresetn),
		.key_wr(key_wr),
		.key_val(hwdata),
		.ctl_wr(ctl_wr),
		.other(other),
		.open(open)
	);

	// ****************
	// address, data and source registers
	// ****************
	logic [31:0] addr_q;
	logic [31:0] data_q;
	logic [31:0] src_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_q <= fpe_pkg::REG_RST;
		end else if (wr_ev && hit_addr) begin
			addr_q <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			data_q <= fpe_pkg::REG_RST;
		end else if (wr_ev && hit_data) begin
			data_q <= hwdata;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_q <= fpe_pkg::REG_RST;
		end else if (wr_ev && hit_src) begin
			src_q <= hwdata;
		end
	end

	// ****************
	// control register
	// ****************
	logic       arm_q;
	logic       go_q;
	logic       err_q;
	logic [3:0] op_q;
	logic       go;
	logic       fin;
	logic       act_q;
	fpe_pkg::fpe_sq_e sq_q;

	assign go = ctl_wr && hwdata[fpe_pkg::CTL_GO] && arm_q && open && !go_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			arm_q <= 1'b0;
		end else if (ctl_wr) begin
			arm_q <= hwdata[fpe_pkg::CTL_ARM];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_q <= fpe_pkg::OP_RST;
		end else if (ctl_wr && !arm_q) begin
			op_q <= hwdata[fpe_pkg::OP_W-1:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			go_q <= 1'b0;
		end else if (go) begin
			go_q <= 1'b1;
		end else if (fin) begin
			go_q <= 1'b0;
		end
	end

	// ****************
	// operation sequencer
	// ****************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sq_q <= fpe_pkg::SQ_IDLE;
		end else begin
			case (sq_q)
				fpe_pkg::SQ_IDLE: begin
					if (go) begin
						sq_q <= fpe_pkg::SQ_BUSY;
					end
				end
				fpe_pkg::SQ_BUSY: begin
					if (fin) begin
						sq_q <= fpe_pkg::SQ_IDLE;
					end
				end
				default: begin
					sq_q <= fpe_pkg::SQ_IDLE;
				end
			endcase
		end
	end

	// launch latches operation, address and data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_q <= 1'b0;
			flash_op <= fpe_pkg::OP_RST;
			flash_addr <= fpe_pkg::REG_RST;
			flash_wdata <= fpe_pkg::REG_RST;
			flash_src <= fpe_pkg::REG_RST;
		end else if (go) begin
			flash_op <= op_q;
			flash_wdata <= fpe_pkg::REG_RST;
			flash_src <= fpe_pkg::REG_RST;
			flash_addr <= addr_q;
			case (op_q)
				fpe_pkg::OP_WORD: begin
					act_q <= 1'b1;
					flash_wdata <= data_q;
				end
				fpe_pkg::OP_ROW: begin
					act_q <= 1'b1;
					flash_src <= src_q;
				end
				fpe_pkg::OP_PAGE: begin
					act_q <= 1'b1;
				end
				fpe_pkg::OP_ALL: begin
					act_q <= 1'b1;
					flash_addr <= fpe_pkg::REG_RST;
				end
				default: begin
					act_q <= 1'b0;
				end
			endcase
		end
	end

	assign flash_req = (sq_q == fpe_pkg::SQ_BUSY) && act_q;
	assign fin = (sq_q == fpe_pkg::SQ_BUSY) && (!act_q || flash_done);

	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			err_q <= 1'b0;
		end else if (flash_req && flash_done) begin
			err_q <= flash_fail;
		end else if (fin && flash_op == fpe_pkg::OP_NONE) begin
			err_q <= 1'b0;
		end
	end

	// ****************
	// interrupt status and mask
	// ****************
	logic [fpe_pkg::ST_W-1:0] st_set;
	logic [fpe_pkg::ST_W-1:0] stat;
	logic [fpe_pkg::ST_W-1:0] mask_q;

	assign st_set[fpe_pkg::ST_DONE] = fin;
	assign st_set[fpe_pkg::ST_ERR] = flash_req && flash_done && flash_fail;

	fpe_sticky #(
		.W(fpe_pkg::ST_W)
	) u_stat (
		.hclk(hclk),
		.hresetn(hresetn),
		.set(st_set),
		.clr(rd_ev && hit_stat),
		.q(stat)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_q <= fpe_pkg::ST_RST;
		end else if (wr_ev && hit_mask) begin
			mask_q <= hwdata[fpe_pkg::ST_W-1:0];
		end
	end

	assign irq = |(stat & mask_q);

	// ****************
	// read data
	// ****************
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_ctl) begin
			rd_mux = {16'h0000, go_q, arm_q, err_q, 9'h000, op_q};
		end else if (hit_key) begin
			rd_mux = 32'h00000000;
		end else if (hit_addr) begin
			rd_mux = addr_q;
		end else if (hit_data) begin
			rd_mux = data_q;
		end else if (hit_src) begin
			rd_mux = src_q;
		end else if (hit_stat) begin
			rd_mux = {30'h00000000, stat};
		end else if (hit_mask) begin
			rd_mux = {30'h00000000, mask_q};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (rd_ev) begin
			hrdata <= rd_mux;
		end
	end

	// ****************
	// checks
	// ****************
	sequence s_launch;
		ctl_wr && hwdata[fpe_pkg::CTL_GO] && arm_q && open && !go_q;
	endsequence

	sequence s_busy_to_done;
		flash_req && flash_done;
	endsequence

	a_key_reads_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_ev && hit_key |=> hrdata == 32'h00000000)
		else $error("key register read back nonzero");

	a_start_unlocked: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(go_q) |-> $past(open) && $past(arm_q))
		else $error("operation started without unlock");

	a_erase_no_addr: assert property (@(posedge hclk) disable iff (!hresetn)
		flash_req && flash_op == fpe_pkg::OP_ALL |-> flash_addr == 32'h00000000)
		else $error("full erase carried an address");

	a_page_addr_used: assert property (@(posedge hclk) disable iff (!hresetn)
		s_launch ##0 (op_q == fpe_pkg::OP_PAGE) |=> flash_req && flash_addr == $past(addr_q))
		else $error("page erase address wrong");

	a_row_src_used: assert property (@(posedge hclk) disable iff (!hresetn)
		s_launch ##0 (op_q == fpe_pkg::OP_ROW) |=> flash_src == $past(src_q) && flash_addr == $past(addr_q))
		else $error("row program source or address wrong");

	a_word_data_used: assert property (@(posedge hclk) disable iff (!hresetn)
		s_launch ##0 (op_q == fpe_pkg::OP_WORD) |=> flash_wdata == $past(data_q) && flash_addr == $past(addr_q))
		else $error("word program data or address wrong");

	a_nop_no_req: assert property (@(posedge hclk) disable iff (!hresetn)
		s_launch ##0 (op_q == fpe_pkg::OP_NONE || op_q == 4'h2 || op_q == 4'h6) |=> !flash_req ##1 !go_q)
		else $error("no-op code drove the array");

	a_go_cleared: assert property (@(posedge hclk) disable iff (!hresetn)
		s_busy_to_done |=> !go_q && !flash_req)
		else $error("trigger not cleared at completion");

	a_op_locked: assert property (@(posedge hclk) disable iff (!hresetn)
		arm_q && $past(arm_q) |-> $stable(op_q))
		else $error("operation select changed while armed");

	a_err_tracks: assert property (@(posedge hclk) disable iff (!hresetn || !por_n)
		s_busy_to_done |=> err_q == $past(flash_fail))
		else $error("error flag does not follow outcome");

endmodule : fpe_regs
`default_nettype wire

// [bench/fpe_flash_model.sv]
`timescale 1ns/1ns
`default_nettype none
module fpe_flash_model (
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// bench control
	input  wire logic [3:0] delay,
	input  wire logic       fail_en,
	// flash link
	input  wire logic       flash_req,
	output logic            flash_done,
	output logic            flash_fail
);
	// ****************
	// answer timing
	// ****************
	logic [4:0] cnt_q;
	logic       tog_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 5'h00;
		end else if (flash_req) begin
			cnt_q <= cnt_q + 5'h01;
		end else begin
			cnt_q <= 5'h00;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tog_q <= 1'h0;
		end else begin
			tog_q <= !tog_q;
		end
	end

	// one-cycle done pulse, fail only meaningful beside it
	assign flash_done = flash_req && (cnt_q == {1'h0, delay});
	assign flash_fail = flash_done ? fail_en : tog_q;
endmodule : fpe_flash_model
`default_nettype wire

// [bench/tb_flash_program_erase_regs.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_flash_program_erase_regs;
	logic        hclk, hresetn, por_n, hsel, hwrite, fail_en, err_e;
	logic        hreadyout, hresp, flash_req, flash_done, flash_fail, irq;
	logic [1:0]  htrans;
	logic [3:0]  flash_op, delay;
	logic [31:0] haddr, hwdata, hrdata, flash_addr, flash_wdata, flash_src, rd;
	int          failures, tests_run, cyc;

	fpe_regs dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_req(flash_req),
		.flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
		.flash_src(flash_src), .flash_done(flash_done), .flash_fail(flash_fail), .irq(irq));
	fpe_flash_model fm (.hclk(hclk), .hresetn(hresetn), .delay(delay), .fail_en(fail_en),
		.flash_req(flash_req), .flash_done(flash_done), .flash_fail(flash_fail));

	// ****************
	// helpers
	// ****************
	task summarize;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : summarize

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task bus(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= {16'h0000, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'h1) @(posedge hclk);
		rd = hrdata;
	endtask : bus

	task wr(input logic [15:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
	endtask : wr

	task rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h00000000);
		chk(nm, e, rd);
		chk("hresp okay", 32'h00000000, {31'h0, hresp});
	endtask : rdchk

	task noreq;
		repeat (5) begin
			@(posedge hclk);
			chk("flash_req idle", 32'h00000000, {31'h0, flash_req});
		end
	endtask : noreq

	task launch(input logic [3:0] op, input logic fl, input logic [3:0] dly);
		fail_en <= fl;
		delay <= dly;
		wr(fpe_pkg::OFF_CTL, 32'h00000000);
		wr(fpe_pkg::OFF_CTL, {28'h0000000, op});
		wr(fpe_pkg::OFF_CTL, {28'h0000400, op});
		wr(fpe_pkg::OFF_KEY, fpe_pkg::KEY1_DEF);
		wr(fpe_pkg::OFF_KEY, fpe_pkg::KEY2_DEF);
		wr(fpe_pkg::OFF_CTL, {28'h0000C00, op});
	endtask : launch

	// ****************
	// scenarios
	// ****************
	task t_resets_vals;
		logic [15:0] offs [8];
		offs = '{fpe_pkg::OFF_CTL, fpe_pkg::OFF_KEY, fpe_pkg::OFF_ADDR, fpe_pkg::OFF_DATA,
			fpe_pkg::OFF_SRC, fpe_pkg::OFF_STAT, fpe_pkg::OFF_MASK, 16'hF470};
		wr(16'hF470, 32'hFFFFFFFF);
		foreach (offs[i]) rdchk("reset value", offs[i], fpe_pkg::REG_RST);
		wr(fpe_pkg::OFF_KEY, 32'hA5A5F00F);
		rdchk("key readback", fpe_pkg::OFF_KEY, 32'h00000000);
	endtask : t_resets_vals

	task t_lock;
		wr(fpe_pkg::OFF_CTL, 32'h00000001);
		wr(fpe_pkg::OFF_CTL, 32'h00004001);
		wr(fpe_pkg::OFF_CTL, 32'h0000C001);
		noreq();
		rdchk("ctl no keys", fpe_pkg::OFF_CTL, 32'h00004001);
		wr(fpe_pkg::OFF_KEY, fpe_pkg::KEY1_DEF);
		rdchk("key between", fpe_pkg::OFF_KEY, 32'h00000000);
		wr(fpe_pkg::OFF_KEY, fpe_pkg::KEY2_DEF);
		wr(fpe_pkg::OFF_CTL, 32'h0000C001);
		noreq();
		wr(fpe_pkg::OFF_KEY, fpe_pkg::KEY2_DEF);
		wr(fpe_pkg::OFF_KEY, fpe_pkg::KEY1_DEF);
		wr(fpe_pkg::OFF_CTL, 32'h0000C001);
		noreq();
	endtask : t_lock

	task t_ops;
		logic [3:0] ops [8];
		logic       fl;
		int         n;
		ops = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h1, 4'h2, 4'h6, 4'h0};
		wr(fpe_pkg::OFF_ADDR, 32'h00012340);
		wr(fpe_pkg::OFF_DATA, 32'hDEADBEEF);
		wr(fpe_pkg::OFF_SRC, 32'h00A00100);
		rdchk("addr rw", fpe_pkg::OFF_ADDR, 32'h00012340);
		rdchk("src rw", fpe_pkg::OFF_SRC, 32'h00A00100);
		wr(fpe_pkg::OFF_MASK, 32'h00000003);
		foreach (ops[i]) begin
			fl = (i == 4);
			launch(ops[i], fl, 4'(i * 2));
			if (ops[i] inside {4'h1, 4'h3, 4'h4, 4'h5}) begin
				n = 0;
				while (flash_req !== 1'h1 && n < 20) begin
					@(posedge hclk);
					n++;
				end
				chk("flash_req", 32'h00000001, {31'h0, flash_req});
				chk("flash_op", {28'h0, ops[i]}, {28'h0, flash_op});
				chk("flash_addr", (ops[i] == 4'h5) ? 32'h0 : 32'h00012340, flash_addr);
				chk("flash_wdata", (ops[i] == 4'h1) ? 32'hDEADBEEF : 32'h0, flash_wdata);
				chk("flash_src", (ops[i] == 4'h3) ? 32'h00A00100 : 32'h0, flash_src);
				while (flash_req === 1'h1 && n < 60) begin
					@(posedge hclk);
					n++;
				end
				err_e = fl;
			end else begin
				noreq();
				if (ops[i] == 4'h0) err_e = 1'h0;
			end
			rdchk("ctl after", fpe_pkg::OFF_CTL, {17'h00000, 1'h1, err_e, 9'h000, ops[i]});
			chk("irq pending", 32'h00000001, {31'h0, irq});
			bus(1'h0, fpe_pkg::OFF_STAT, 32'h00000000);
			chk("stat done", 32'h00000001, {31'h0, rd[0]});
			chk("irq cleared", 32'h00000000, {31'h0, irq});
		end
		wr(fpe_pkg::OFF_CTL, 32'h00004005);
		rdchk("op locked", fpe_pkg::OFF_CTL, 32'h00004000);
	endtask : t_ops

	task t_irq_mask;
		wr(fpe_pkg::OFF_MASK, 32'h00000000);
		launch(4'h6, 1'h0, 4'h0);
		repeat (3) @(posedge hclk);
		chk("irq masked", 32'h00000000, {31'h0, irq});
		rdchk("mask rw", fpe_pkg::OFF_MASK, 32'h00000000);
		wr(fpe_pkg::OFF_MASK, 32'h00000001);
		@(posedge hclk);
		chk("irq unmasked", 32'h00000001, {31'h0, irq});
		rdchk("stat read", fpe_pkg::OFF_STAT, 32'h00000001);
		chk("irq after read", 32'h00000000, {31'h0, irq});
	endtask : t_irq_mask

	task t_reset_kinds;
		wr(fpe_pkg::OFF_DATA, 32'hAAAA5555);
		@(posedge hclk);
		hresetn <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		rdchk("data kept", fpe_pkg::OFF_DATA, 32'hAAAA5555);
		rdchk("addr reset", fpe_pkg::OFF_ADDR, 32'h00000000);
		@(posedge hclk);
		hresetn <= 1'h0;
		por_n <= 1'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		por_n <= 1'h1;
		rdchk("data por", fpe_pkg::OFF_DATA, 32'h00000000);
	endtask : t_reset_kinds

	// ****************
	// run control
	// ****************
	initial begin
		hclk = 1'h0;
		forever #5 hclk = !hclk;
	end

	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			summarize();
		end
	end

	initial begin
		{hresetn, por_n, hsel, hwrite, fail_en, err_e} = 6'h00;
		{htrans, delay, haddr, hwdata} = 70'h0;
		failures = 0;
		tests_run = 0;
		cyc = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'h1;
		por_n <= 1'h1;
		t_resets_vals();
		t_lock();
		t_ops();
		t_irq_mask();
		t_reset_kinds();
		summarize();
	end
endmodule : tb_flash_program_erase_regs
`default_nettype wire
